/* ipg_cfg.svh */
// address map, reset values and timing counts of the inverter pwm block
`ifndef IPG_CFG_SVH
`define IPG_CFG_SVH

// =====================================================================
// register byte offsets
`define IPG_OFS_CTRL 8'h00
`define IPG_OFS_PERIOD 8'h04
`define IPG_OFS_ACTION 8'h08
`define IPG_OFS_DBCTRL 8'h0C
`define IPG_OFS_RED 8'h10
`define IPG_OFS_FED 8'h14
`define IPG_OFS_COMPARE_C_VALUE 8'h18
`define IPG_OFS_STATUS 8'h1C
`define IPG_OFS_CMPA0 8'h20
`define IPG_COMPARE_A_VALUE_STRIDE 8'h04

// =====================================================================
// field positions
`define IPG_CTRL_FORCE_BIT 0
`define IPG_CTRL_IRQSEL_BIT 1
`define IPG_CTRL_TRIPCLR_BIT 2
`define IPG_CTRL_SYNC_BIT 3
`define IPG_ACT_UP_LSB 0
`define IPG_ACT_DOWN_LSB 2
`define IPG_DB_EN_BIT 0
`define IPG_ST_DIR_BIT 16
`define IPG_ST_TRIP_BIT 17
`define IPG_ST_OUT_LSB 18

// =====================================================================
// reset values and counts
`define IPG_PERIOD_RST 16'h07D0
`define IPG_COMPARE_A_VALUE_RST 16'h0000
`define IPG_COMPARE_C_VALUE_RST 16'h0064
`define IPG_RED_RST 10'h014
`define IPG_FED_RST 10'h014
`define IPG_ACT_UP_RST 2'h1
`define IPG_ACT_DOWN_RST 2'h2
`define IPG_CLK_MHZ 125

`endif

/* ipg_pkg.sv */
// types shared by the inverter pwm block
package ipg_pkg;

  // =====================================================================
  // output actions of the action qualifier
  typedef enum logic [1:0] {
    IPG_ACT_NONE = 2'b00,
    IPG_ACT_LOW = 2'b01,
    IPG_ACT_HIGH = 2'b10,
    IPG_ACT_TOGGLE = 2'b11
  } ipg_act_e;

  // =====================================================================
  // wishbone carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } ipg_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } ipg_wb_rsp_s;

  // dead-band settings
  typedef struct packed {
    logic enable;
    logic [9:0] rising_delay;
    logic [9:0] fed;
  } ipg_db_s;

endpackage

/* ipg_pwm_deadband.sv */
// six-instance up-down pwm generator with dead band, trip and triggers
`timescale 1ns/1ps
`default_nettype none
`include "ipg_cfg.svh"

// Notes on behaviour
// - six instances, twelve gate outputs
// - symmetric up-down counting, 31.25 kHz switching
// - period 2000, reverse at period and zero
// - period shadow loads at counter zero
// - start at zero, sync resumes upward below period
// - sync-out pulse at counter zero
// - compare A shadowed, loads zero or period
// - up match low, down match high
// - other events leave A unchanged
// - actions load globally at counter zero
// - continuous force holds A low
// - B via dead band, 20 counts
// - rising path kept, falling inverted
// - dead-band counters run each clock
// - rising delay at period, others zero
// - trigger events taken from event A1
// - first instance raises loop interrupt
// - interrupt drives crossbar output zero
// - A1 or B1 trip latches outputs low
module ipg_pwm_deadband
  import ipg_pkg::*;
#(
  parameter int NUM_INST = 6,
  parameter int CTR_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register bus
  input wire ipg_wb_req_s wbReq,
  output ipg_wb_rsp_s wbRsp,
  // trip pins from the digital compare events
  input wire logic compareEventA1,
  input wire logic compareEventB1,
  // gate drives
  output logic [NUM_INST-1:0] primaryOut,
  output logic [NUM_INST-1:0] complementaryOut,
  // timing outputs
  output logic [NUM_INST-1:0] syncOut,
  output logic conversionTriggerA,
  output logic conversionTriggerB,
  output logic crossbarOutputZero
);

  // =====================================================================
  // state
  logic [CTR_W-1:0] ctr;
  logic dirUp;
  logic [CTR_W-1:0] prdShadow;
  logic [CTR_W-1:0] prdActive;
  logic [CTR_W-1:0] cmpaShadow [NUM_INST];
  logic [CTR_W-1:0] cmpaActive [NUM_INST];
  logic [CTR_W-1:0] compare_c_value;
  ipg_act_e actUpShadow;
  ipg_act_e actDownShadow;
  ipg_act_e actUpActive;
  ipg_act_e actDownActive;
  logic forceShadow;
  logic forceActive;
  logic irqSelCmpc;
  ipg_db_s dbShadow;
  ipg_db_s dbActive;
  logic tripA1Meta;
  logic tripA1;
  logic tripB1Meta;
  logic tripB1;
  logic tripLatched;
  logic [NUM_INST-1:0] aqOut;
  logic [NUM_INST-1:0] redOut;
  logic [NUM_INST-1:0] fedOut;
  logic [NUM_INST-1:0] upMatch;
  logic [NUM_INST-1:0] downMatch;
  logic zeroEv;
  logic prdEv;
  logic wbAcc;
  logic wbWr;
  logic tripClrReq;
  logic syncReq;
  logic trigEvent;
  logic [31:0] next_rdData;

  // =====================================================================
  // wishbone slave
  function automatic logic [31:0] wbMerge(input logic [31:0] old, input logic [31:0] din,
                                          input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = din[8*b +: 8];
      end
    end
    return res;
  endfunction

  assign wbAcc = wbReq.cyc & wbReq.stb & ~wbRsp.ack;
  assign wbWr = wbAcc & wbReq.we;
  assign tripClrReq = wbWr && wbReq.adr == `IPG_OFS_CTRL && wbReq.sel[0] &&
                      wbReq.dat[`IPG_CTRL_TRIPCLR_BIT];
  assign syncReq = wbWr && wbReq.adr == `IPG_OFS_CTRL && wbReq.sel[0] &&
                   wbReq.dat[`IPG_CTRL_SYNC_BIT];

  always_comb begin
    next_rdData = 32'h0000_0000;
    unique case (wbReq.adr)
      `IPG_OFS_CTRL: begin
        next_rdData[`IPG_CTRL_FORCE_BIT] = forceShadow;
        next_rdData[`IPG_CTRL_IRQSEL_BIT] = irqSelCmpc;
      end
      `IPG_OFS_PERIOD: next_rdData[CTR_W-1:0] = prdShadow;
      `IPG_OFS_ACTION: begin
        next_rdData[`IPG_ACT_UP_LSB +: 2] = actUpShadow;
        next_rdData[`IPG_ACT_DOWN_LSB +: 2] = actDownShadow;
      end
      `IPG_OFS_DBCTRL: next_rdData[`IPG_DB_EN_BIT] = dbShadow.enable;
      `IPG_OFS_RED: next_rdData[9:0] = dbShadow.rising_delay;
      `IPG_OFS_FED: next_rdData[9:0] = dbShadow.fed;
      `IPG_OFS_COMPARE_C_VALUE: next_rdData[CTR_W-1:0] = compare_c_value;
      `IPG_OFS_STATUS: begin
        next_rdData[CTR_W-1:0] = ctr;
        next_rdData[`IPG_ST_DIR_BIT] = dirUp;
        next_rdData[`IPG_ST_TRIP_BIT] = tripLatched;
        next_rdData[`IPG_ST_OUT_LSB +: NUM_INST] = primaryOut;
      end
      default: begin
        for (int k = 0; k < NUM_INST; k++) begin
          if (wbReq.adr == 8'(`IPG_OFS_CMPA0 + k * `IPG_COMPARE_A_VALUE_STRIDE)) begin
            next_rdData[CTR_W-1:0] = cmpaShadow[k];
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wbRsp <= '0;
    end else begin
      wbRsp.ack <= wbAcc;
      wbRsp.dat <= wbAcc ? next_rdData : 32'h0000_0000;
    end
  end

  // software-written settings
  always_ff @(posedge core_clk) begin
    if (srst) begin
      forceShadow <= 1'b0;
      irqSelCmpc <= 1'b0;
      prdShadow <= `IPG_PERIOD_RST;
      actUpShadow <= ipg_act_e'(`IPG_ACT_UP_RST);
      actDownShadow <= ipg_act_e'(`IPG_ACT_DOWN_RST);
      dbShadow.enable <= 1'b1;
      dbShadow.rising_delay <= `IPG_RED_RST;
      dbShadow.fed <= `IPG_FED_RST;
      compare_c_value <= `IPG_COMPARE_C_VALUE_RST;
    end else if (wbWr) begin
      unique case (wbReq.adr)
        `IPG_OFS_CTRL: begin
          if (wbReq.sel[0]) begin
            forceShadow <= wbReq.dat[`IPG_CTRL_FORCE_BIT];
            irqSelCmpc <= wbReq.dat[`IPG_CTRL_IRQSEL_BIT];
          end
        end
        `IPG_OFS_PERIOD: prdShadow <= CTR_W'(wbMerge(32'(prdShadow), wbReq.dat, wbReq.sel));
        `IPG_OFS_ACTION: begin
          if (wbReq.sel[0]) begin
            actUpShadow <= ipg_act_e'(wbReq.dat[`IPG_ACT_UP_LSB +: 2]);
            actDownShadow <= ipg_act_e'(wbReq.dat[`IPG_ACT_DOWN_LSB +: 2]);
          end
        end
        `IPG_OFS_DBCTRL: begin
          if (wbReq.sel[0]) begin
            dbShadow.enable <= wbReq.dat[`IPG_DB_EN_BIT];
          end
        end
        `IPG_OFS_RED: dbShadow.rising_delay <= 10'(wbMerge(32'(dbShadow.rising_delay), wbReq.dat, wbReq.sel));
        `IPG_OFS_FED: dbShadow.fed <= 10'(wbMerge(32'(dbShadow.fed), wbReq.dat, wbReq.sel));
        `IPG_OFS_COMPARE_C_VALUE: compare_c_value <= CTR_W'(wbMerge(32'(compare_c_value), wbReq.dat, wbReq.sel));
        default: ;
      endcase
    end
  end

  // =====================================================================
  // time base, shared so all instances stay aligned; it never halts
  assign zeroEv = ctr == '0;
  assign prdEv = ctr == prdActive;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctr <= '0;
      dirUp <= 1'b1;
    end else if (syncReq || dirUp) begin
      // a sync forces the count upward unless it is at or above the period, no phase load
      if (ctr >= prdActive) begin
        dirUp <= 1'b0;
        ctr <= ctr - 1'b1;
      end else begin
        dirUp <= 1'b1;
        ctr <= ctr + 1'b1;
      end
    end else if (zeroEv) begin
      dirUp <= 1'b1;
      ctr <= ctr + 1'b1;
    end else begin
      ctr <= ctr - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdActive <= `IPG_PERIOD_RST;
    end else if (zeroEv) begin
      prdActive <= prdShadow;
    end
  end

  // global shadow loads: one register set feeds every instance
  always_ff @(posedge core_clk) begin
    if (srst) begin
      actUpActive <= ipg_act_e'(`IPG_ACT_UP_RST);
      actDownActive <= ipg_act_e'(`IPG_ACT_DOWN_RST);
      forceActive <= 1'b0;
      dbActive.enable <= 1'b1;
      dbActive.rising_delay <= `IPG_RED_RST;
      dbActive.fed <= `IPG_FED_RST;
    end else begin
      if (zeroEv) begin
        actUpActive <= actUpShadow;
        actDownActive <= actDownShadow;
        dbActive.enable <= dbShadow.enable;
        dbActive.fed <= dbShadow.fed;
      end
      if (prdEv) begin
        dbActive.rising_delay <= dbShadow.rising_delay;
      end
      if (zeroEv || prdEv) begin
        forceActive <= forceShadow;
      end
    end
  end

  // =====================================================================
  // trip inputs and one-shot latch
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tripA1Meta <= 1'b0;
      tripA1 <= 1'b0;
      tripB1Meta <= 1'b0;
      tripB1 <= 1'b0;
    end else begin
      tripA1Meta <= compareEventA1;
      tripA1 <= tripA1Meta;
      tripB1Meta <= compareEventB1;
      tripB1 <= tripB1Meta;
    end
  end

  // a new trip wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tripLatched <= 1'b0;
    end else if (tripA1 || tripB1) begin
      tripLatched <= 1'b1;
    end else if (tripClrReq) begin
      tripLatched <= 1'b0;
    end
  end

  // both trigger-event inputs see event A1; their actions are no-change
  assign trigEvent = tripA1;

  // =====================================================================
  // per-instance compare, action qualifier and dead band
  function automatic logic applyAct(input logic cur, input ipg_act_e act);
    logic res;
    res = cur;
    unique case (act)
      IPG_ACT_NONE: res = cur;
      IPG_ACT_LOW: res = 1'b0;
      IPG_ACT_HIGH: res = 1'b1;
      IPG_ACT_TOGGLE: res = ~cur;
    endcase
    return res;
  endfunction

  for (genvar i = 0; i < NUM_INST; i++) begin : g_inst
    logic [9:0] redCnt;
    logic [9:0] fedCnt;

    always_ff @(posedge core_clk) begin
      if (srst) begin
        cmpaShadow[i] <= `IPG_COMPARE_A_VALUE_RST;
        cmpaActive[i] <= `IPG_COMPARE_A_VALUE_RST;
      end else begin
        if (wbWr && wbReq.adr == 8'(`IPG_OFS_CMPA0 + i * `IPG_COMPARE_A_VALUE_STRIDE)) begin
          cmpaShadow[i] <= CTR_W'(wbMerge(32'(cmpaShadow[i]), wbReq.dat, wbReq.sel));
        end
        if (zeroEv || prdEv) begin
          cmpaActive[i] <= cmpaShadow[i];
        end
      end
    end

    assign upMatch[i] = dirUp && ctr == cmpaActive[i];
    assign downMatch[i] = !dirUp && ctr == cmpaActive[i];

    // only the force and compare A matches move the output
    always_ff @(posedge core_clk) begin
      if (srst) begin
        aqOut[i] <= 1'b0;
      end else if (forceActive) begin
        aqOut[i] <= 1'b0;
      end else if (upMatch[i]) begin
        aqOut[i] <= applyAct(aqOut[i], actUpActive);
      end else if (downMatch[i]) begin
        aqOut[i] <= applyAct(aqOut[i], actDownActive);
      end
    end

    // delay counters advance every clock
    always_ff @(posedge core_clk) begin
      if (srst) begin
        redCnt <= '0;
        redOut[i] <= 1'b0;
      end else if (!aqOut[i]) begin
        redCnt <= '0;
        redOut[i] <= 1'b0;
      end else if (redCnt >= dbActive.rising_delay) begin
        redOut[i] <= 1'b1;
      end else begin
        redCnt <= redCnt + 1'b1;
      end
    end

    always_ff @(posedge core_clk) begin
      if (srst) begin
        fedCnt <= '0;
        fedOut[i] <= 1'b0;
      end else if (aqOut[i]) begin
        fedCnt <= '0;
        fedOut[i] <= 1'b1;
      end else if (fedCnt >= dbActive.fed) begin
        fedOut[i] <= 1'b0;
      end else begin
        fedCnt <= fedCnt + 1'b1;
      end
    end

    // rising path keeps polarity, falling path inverted, no swap
    always_ff @(posedge core_clk) begin
      if (srst) begin
        primaryOut[i] <= 1'b0;
        complementaryOut[i] <= 1'b0;
      end else if (tripLatched) begin
        primaryOut[i] <= 1'b0;
        complementaryOut[i] <= 1'b0;
      end else if (dbActive.enable) begin
        primaryOut[i] <= redOut[i];
        complementaryOut[i] <= ~fedOut[i];
      end else begin
        primaryOut[i] <= aqOut[i];
        complementaryOut[i] <= ~aqOut[i];
      end
    end
  end

  // =====================================================================
  // sync, conversion triggers and loop interrupt
  always_ff @(posedge core_clk) begin
    if (srst) begin
      syncOut <= '0;
      conversionTriggerA <= 1'b0;
      conversionTriggerB <= 1'b0;
      crossbarOutputZero <= 1'b0;
    end else begin
      syncOut <= {NUM_INST{zeroEv}};
      conversionTriggerA <= zeroEv;
      conversionTriggerB <= prdEv;
      // once per period from the first instance
      crossbarOutputZero <= irqSelCmpc ? (dirUp && ctr == compare_c_value) : zeroEv;
    end
  end

  // =====================================================================
  // assertions
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  a_bus_ack_single: assert property (wbRsp.ack |=> !wbRsp.ack)
    else $error("bus ack held longer than one cycle");
  a_period_shadow_load: assert property (zeroEv |=> prdActive == $past(prdShadow))
    else $error("period did not load at counter zero");
  a_ctr_turn_down: assert property (dirUp && ctr == prdActive && !syncReq && prdActive != '0
                                    |=> !dirUp && ctr == $past(prdActive) - 1'b1)
    else $error("counter did not reverse at period");
  a_sync_at_zero: assert property (!$past(srst) |-> syncOut[0] == $past(zeroEv))
    else $error("sync pulse not aligned to counter zero");
  a_trip_outs_low: assert property (tripLatched |=> primaryOut == '0 && complementaryOut == '0)
    else $error("outputs not low while tripped");
  a_force_holds_low: assert property (forceActive |=> !aqOut[0])
    else $error("forced output not low");
  a_up_match_low: assert property (upMatch[0] && !forceActive && actUpActive == IPG_ACT_LOW
                                   |=> !aqOut[0])
    else $error("up match did not drive A low");
  a_dead_gap: assert property (!(|(primaryOut & complementaryOut)))
    else $error("both outputs of a pair high");
  a_red_delay: assert property ($rose(aqOut[1]) && dbActive.rising_delay == 10'd20 && !tripLatched
                                |-> !primaryOut[1] [*8])
    else $error("rising edge passed before dead band");
  a_trig_b_period: assert property (conversionTriggerB == $past(prdEv))
    else $error("trigger B not at period");
  a_trigger_no_effect: assert property (trigEvent && !upMatch[2] && !downMatch[2]
                                        && !forceActive |=> $stable(aqOut[2]))
    else $error("trigger event moved the output");

  c_trip_seen: cover property (tripLatched ##1 tripClrReq);
  c_irq_pulse: cover property (crossbarOutputZero);
  // length of the current high pulse of the first gate output
  logic [CTR_W-1:0] hiRun;

  always_ff @(posedge core_clk) begin
    if (srst || !primaryOut[0]) begin
      hiRun <= '0;
    end else begin
      hiRun <= hiRun + 1'b1;
    end
  end

  c_duty_edge: cover property ($fell(primaryOut[0]) && hiRun != '0);
  c_bus_write: cover property (wbWr && wbReq.adr == `IPG_OFS_CMPA0);

endmodule

`default_nettype wire

/* ipg_gate_driver_model.sv */
// behavioural gate drivers of the six legs: desaturation fault and overlap watch
`timescale 1ns/1ps
`default_nettype none
module ipg_gate_driver_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // gate commands from the block
  input wire logic [5:0] gateHi,
  input wire logic [5:0] gateLo,
  // fault request from the bench
  input wire logic faultCmd,
  // fault pin and overlap count
  output logic faultOut,
  output var int overlapCnt
);
  // =====================================================================
  // fault pin is a level held while the bench asks for it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      faultOut <= 1'b0;
    end else begin
      faultOut <= faultCmd;
    end
  end

  // =====================================================================
  // shoot-through on any leg is counted for the bench
  always_ff @(posedge core_clk) begin
    if (srst) begin
      overlapCnt <= 0;
    end else if ((gateHi & gateLo) != 6'h00) begin
      overlapCnt <= overlapCnt + 1;
    end
  end
endmodule
`default_nettype wire

/* inverter_pwm_deadband_gen_bench.sv */
// self-checking bench of the inverter pwm block
`timescale 1ns/1ps
`default_nettype none
`include "ipg_cfg.svh"
module inverter_pwm_deadband_gen_bench
  import ipg_pkg::*;
;
  // =====================================================================
  // signals
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  ipg_wb_req_s wbReq = '0;
  ipg_wb_rsp_s wbRsp;
  logic compareEventB1 = 1'b0;
  logic faultCmd = 1'b0;
  logic faultOut;
  logic [5:0] primaryOut;
  logic [5:0] complementaryOut;
  logic [5:0] syncOut;
  logic conversionTriggerA;
  logic conversionTriggerB;
  logic crossbarOutputZero;
  logic [31:0] rd;
  logic [15:0] compare_a_value [6];
  int overlapCnt;
  int n_fail = 0;
  int checked = 0;
  int seed = 32'h4e9f;
  int hi [6];
  int hiAll, nA, nB, nGap, nOff, syncAt, irqAt;
  localparam logic [7:0] regAdr [10] = '{`IPG_OFS_CTRL, `IPG_OFS_PERIOD, `IPG_OFS_ACTION,
    `IPG_OFS_DBCTRL, `IPG_OFS_RED, `IPG_OFS_FED, `IPG_OFS_COMPARE_C_VALUE, `IPG_OFS_CMPA0,
    `IPG_OFS_CMPA0 + 8'h14, 8'h40};
  localparam logic [31:0] regVal [10] = '{32'h0, 32'h7D0, 32'h9, 32'h1, 32'h14, 32'h14,
    32'h64, 32'h0, 32'h0, 32'h0};

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  ipg_pwm_deadband uut (
    .core_clk(core_clk), .srst(srst), .wbReq(wbReq), .wbRsp(wbRsp),
    .compareEventA1(faultOut), .compareEventB1(compareEventB1),
    .primaryOut(primaryOut), .complementaryOut(complementaryOut), .syncOut(syncOut),
    .conversionTriggerA(conversionTriggerA), .conversionTriggerB(conversionTriggerB),
    .crossbarOutputZero(crossbarOutputZero)
  );

  ipg_gate_driver_model drv (
    .core_clk(core_clk), .srst(srst), .gateHi(primaryOut), .gateLo(complementaryOut),
    .faultCmd(faultCmd), .faultOut(faultOut), .overlapCnt(overlapCnt)
  );

  // =====================================================================
  // tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic give_up(int k, int lim);
    if (k >= lim) begin
      n_fail++;
      $display("wrong value wait expected event seen timeout");
      conclude();
    end
  endtask

  task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat);
    int k = 0;
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
    do begin
      @(posedge core_clk);
      k++;
    end while (wbRsp.ack !== 1'b1 && k < 50);
    give_up(k, 50);
    rd = wbRsp.dat;
    wbReq <= '0;
    @(posedge core_clk);
  endtask

  task automatic wait_sync();
    int k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (syncOut[0] !== 1'b1 && k < 5000);
    give_up(k, 5000);
  endtask

  // two zero events so every shadow value is active
  task automatic settle();
    wait_sync();
    wait_sync();
  endtask

  // one full period of observation, starting right after a sync pulse
  task automatic measure(int p);
    nA = 0;
    nB = 0;
    nGap = 0;
    nOff = 0;
    syncAt = -1;
    irqAt = -1;
    foreach (hi[i]) hi[i] = 0;
    wait_sync();
    for (int c = 0; c < 2 * p; c++) begin
      @(posedge core_clk);
      if (syncOut[0] === 1'b1) syncAt = c;
      if (crossbarOutputZero === 1'b1) irqAt = c;
      nA += int'(conversionTriggerA === 1'b1);
      nB += int'(conversionTriggerB === 1'b1);
      nGap += int'(primaryOut[0] === 1'b0 && complementaryOut[0] === 1'b0);
      nOff += int'(complementaryOut !== ~primaryOut);
      for (int i = 0; i < 6; i++) hi[i] += int'(primaryOut[i] === 1'b1);
    end
    hiAll = hi.sum();
  endtask

  task automatic set_duty(int p, bit edgeCase);
    for (int i = 0; i < 6; i++) begin
      compare_a_value[i] = 16'(p / 4 + $unsigned($random(seed)) % (p / 2));
      if (edgeCase && i == 5) compare_a_value[i] = 16'h0001;
      wb(1'b1, `IPG_OFS_CMPA0 + 8'(4 * i), {16'h0, compare_a_value[i]});
    end
  endtask

  // =====================================================================
  // main sequence
  initial begin
    int p;
    int rising_delay;
    int fed;
    repeat (6) @(posedge core_clk);
    chk("sync in reset", 32'h0, {26'h0, syncOut});
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("first sync", 32'h3F, {26'h0, syncOut});
    chk("first trigger", 32'h1, {31'h0, conversionTriggerA});
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    for (int i = 0; i < 10; i++) begin
      wb(1'b0, regAdr[i], 32'h0);
      chk("reset value", regVal[i], rd);
    end
    measure(2000);
    chk("period", 32'd3999, 32'(syncAt));
    chk("irq", 32'd3999, 32'(irqAt));
    chk("trig a", 32'd1, 32'(nA));
    chk("trig b", 32'd1, 32'(nB));
    p = 160 + $unsigned($random(seed)) % 80;
    rising_delay = 4 + $unsigned($random(seed)) % 37;
    fed = 4 + $unsigned($random(seed)) % 37;
    wb(1'b1, `IPG_OFS_PERIOD, 32'(p));
    wb(1'b1, `IPG_OFS_RED, 32'(rising_delay));
    wb(1'b1, `IPG_OFS_FED, 32'(fed));
    set_duty(p, 1'b0);
    settle();
    measure(p);
    chk("new period", 32'(2 * p - 1), 32'(syncAt));
    chk("dead time", 32'(rising_delay + fed), 32'(nGap));
    chk("overlap", 32'd0, 32'(overlapCnt));
    wb(1'b1, `IPG_OFS_DBCTRL, 32'h0);
    for (int k = 0; k < 2; k++) begin
      set_duty(p, k[0]);
      settle();
      measure(p);
      for (int i = 0; i < 6; i++) begin
        chk("duty", 32'(2 * compare_a_value[i]), 32'(hi[i]));
      end
      chk("complement", 32'd0, 32'(nOff));
    end
    wb(1'b1, `IPG_OFS_CTRL, 32'h1);
    settle();
    measure(p);
    chk("forced low", 32'd0, 32'(hiAll));
    wb(1'b1, `IPG_OFS_CTRL, 32'h2);
    settle();
    measure(p);
    chk("irq at compare c", 32'd99, 32'(irqAt));
    wb(1'b1, `IPG_OFS_CTRL, 32'h0);
    wait_sync();
    repeat (p + 5) @(posedge core_clk);
    wb(1'b0, `IPG_OFS_STATUS, 32'h0);
    chk("dir down", 32'h0, {31'h0, rd[`IPG_ST_DIR_BIT]});
    wb(1'b1, `IPG_OFS_CTRL, 32'h8);
    wb(1'b0, `IPG_OFS_STATUS, 32'h0);
    chk("dir after sync", 32'h1, {31'h0, rd[`IPG_ST_DIR_BIT]});
    for (int s = 0; s < 2; s++) begin
      if (s == 0) begin
        faultCmd <= 1'b1;
      end else begin
        compareEventB1 <= 1'b1;
      end
      repeat (8) @(posedge core_clk);
      faultCmd <= 1'b0;
      compareEventB1 <= 1'b0;
      wb(1'b0, `IPG_OFS_STATUS, 32'h0);
      chk("trip flag", 32'h1, {31'h0, rd[`IPG_ST_TRIP_BIT]});
      measure(p);
      chk("tripped", 32'(2 * p), 32'(nOff));
      chk("tripped high", 32'd0, 32'(hiAll));
      wb(1'b1, `IPG_OFS_CTRL, 32'h4);
      settle();
      measure(p);
      chk("restored", 32'(2 * compare_a_value[0]), 32'(hi[0]));
    end
    conclude();
  end
endmodule
`default_nettype wire
